// [rtl/port_b_mux_pkg.sv]
`default_nettype none
package port_b_mux_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [15:0] DIR_INDEX = 16'hFFD4;
  localparam logic [15:0] DATA_INDEX = 16'hFFD6;
  localparam int unsigned MIN_ADDR_W = 18;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_TRIG = 7;
  localparam int unsigned PIN_NOPIN = 6;
  localparam int unsigned PIN_INV_B = 5;
  localparam int unsigned PIN_INV_A = 4;
  localparam int unsigned PIN_IO_B = 3;
  localparam int unsigned PIN_IO_A = 2;
  localparam logic [1:0] IO_CTRL_NONE = 2'h0;
  localparam int unsigned SYNC_STAGES = 3;

  // Timer channel 4 controls, all from on-chip logic
  typedef struct packed {
    logic combination_mode_bit;
    logic pwm_select_ch4;
    logic inv_out_a_enable;
    logic inv_out_b_enable;
    logic out_a_enable;
    logic out_b_enable;
    logic [2:0] a_io_ctrl;
    logic [2:0] b_io_ctrl;
  } timer_ctrl_t;

  // Timer channel 4 output levels toward the pins
  typedef struct packed {
    logic timer4_inverted_out_a;
    logic timer4_inverted_out_b;
    logic timer4_io_a;
    logic timer4_io_b;
  } timer_out_t;

  // Pattern controller link for output groups 2 and 3 (bits 15..8 map to 7..0)
  typedef struct packed {
    logic [7:0] next_data_enable_b;
    logic [7:0] next_data_hold_b;
    logic transfer;
  } pattern_ctrl_t;

  // Signals fed from the pins into the timer and converter
  typedef struct packed {
    logic capture_a;
    logic capture_b;
    logic conv_external_trigger_n;
  } pin_feed_t;

endpackage : port_b_mux_pkg
`default_nettype wire

// [rtl/port_b_pin_function_mux.sv]
// Functional notes
// - Same pin functions in every operating mode
// - Direction bit 1 output, 0 input
// - Direction register reads back all ones
// - Direction clears on reset and hardware standby
// - Output pins keep driving in software standby
// - Data read: stored bit if output, else pin
// - Bit 6 is storage only, no pin
// - Bit 6 reads stored if direction set, else 1
// - Data clears on reset and hardware standby
// - Data bits feed pattern output groups 2, 3
// - Pattern-enabled bits ignore writes, load on transfer
// - Pin 7: input, port output or pattern output
// - Pin 7 feeds converter trigger when enabled
// - Pin 5 inverted timer B output when enabled
// - Pin 4 inverted timer A output when enabled
// - Pin 3 timer compare B output when selected
// - Pin 3 feeds capture B when selected
// - Pin 2 chooses timer A, port or pattern
`default_nettype none
module port_b_pin_function_mux #(
  parameter int unsigned ADDR_W = 18
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hw_standby,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire port_b_mux_pkg::timer_ctrl_t timer_ctrl,
  input wire port_b_mux_pkg::timer_out_t timer_out,
  input wire port_b_mux_pkg::pattern_ctrl_t pattern_ctrl,
  input wire logic conv_trigger_enable,
  output port_b_mux_pkg::pin_feed_t pin_feed,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);
  import port_b_mux_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < MIN_ADDR_W)
  begin : g_addr_check
    $error("ADDR_W too small to reach the register addresses");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // Pin input sampling
  // ----------------------------------------------------------------
  // Level accepted only when stages two and three agree
  logic [SYNC_STAGES-1:0] pin_sync [8];
  logic [7:0] pin_level;

  for (genvar i = 0; i < 8; i++)
  begin : g_sync
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        pin_sync[i] <= '0;
      else
        pin_sync[i] <= {pin_sync[i][SYNC_STAGES-2:0], pin_in[i]};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        pin_level[i] <= 1'b0;
      else if (pin_sync[i][1] == pin_sync[i][2])
        pin_level[i] <= pin_sync[i][2];
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DIR_ADDR = ADDR_W'({DIR_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] DATA_ADDR = ADDR_W'({DATA_INDEX, 2'b00});

  logic ack;
  logic hit_dir;
  logic hit_data;
  logic wr_dir;
  logic wr_data;

  assign hit_dir = (avs_address == DIR_ADDR);
  assign hit_data = (avs_address == DATA_ADDR);
  // One wait cycle per access; the answer comes on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_dir = avs_write & ack & hit_dir & avs_byteenable[0];
  assign wr_data = avs_write & ack & hit_data & avs_byteenable[0];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  // ----------------------------------------------------------------
  // Direction register
  // ----------------------------------------------------------------
  logic [7:0] pin_direction_select;

  // Software standby has no path here, so state simply stays
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_direction_select <= DIR_RESET;
    else if (hw_standby)
      pin_direction_select <= DIR_RESET;
    else if (wr_dir)
      pin_direction_select <= avs_writedata[7:0];
  end

  // ----------------------------------------------------------------
  // Data register
  // ----------------------------------------------------------------
  logic [7:0] pin_output_data;
  logic [7:0] pattern_en;

  // No pattern enable exists for the pinless bit
  assign pattern_en = pattern_ctrl.next_data_enable_b & ~(8'h01 << PIN_NOPIN);

  for (genvar i = 0; i < 8; i++)
  begin : g_data
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        pin_output_data[i] <= DATA_RESET[i];
      else if (hw_standby)
        pin_output_data[i] <= DATA_RESET[i];
      else if (pattern_en[i])
      begin
        if (pattern_ctrl.transfer)
          pin_output_data[i] <= pattern_ctrl.next_data_hold_b[i];
      end
      else if (wr_data)
        pin_output_data[i] <= avs_writedata[i];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] data_view;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      data_view[i] = pin_direction_select[i] ? pin_output_data[i] : pin_level[i];
    data_view[PIN_NOPIN] = pin_direction_select[PIN_NOPIN] ? pin_output_data[PIN_NOPIN] : 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= UNMAPPED_READ;
    else if (avs_read & ~ack)
    begin
      if (hit_dir)
        avs_readdata <= {24'h00_0000, DIR_READ_VALUE};
      else if (hit_data)
        avs_readdata <= {24'h00_0000, data_view};
      else
        avs_readdata <= UNMAPPED_READ;
    end
  end

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  // No mode input exists: the selection is identical in every mode
  logic inv_b_sel;
  logic inv_a_sel;
  logic io_b_sel;
  logic io_a_sel;
  logic [7:0] next_out;
  logic [7:0] next_oe;

  assign inv_b_sel = timer_ctrl.combination_mode_bit & timer_ctrl.inv_out_b_enable;
  assign inv_a_sel = timer_ctrl.combination_mode_bit & timer_ctrl.inv_out_a_enable;
  assign io_b_sel = timer_ctrl.out_b_enable & (timer_ctrl.combination_mode_bit
                    | (~timer_ctrl.b_io_ctrl[2] & (timer_ctrl.b_io_ctrl[1:0] != IO_CTRL_NONE)));
  assign io_a_sel = timer_ctrl.out_a_enable & (timer_ctrl.combination_mode_bit | timer_ctrl.pwm_select_ch4
                    | (~timer_ctrl.a_io_ctrl[2] & (timer_ctrl.a_io_ctrl[1:0] != IO_CTRL_NONE)));

  always_comb
  begin
    // Pattern output and port output both drive the data bit
    next_out = pin_output_data;
    next_oe = pin_direction_select;
    next_oe[PIN_NOPIN] = 1'b0;
    next_out[PIN_NOPIN] = 1'b0;
    if (inv_b_sel)
    begin
      next_out[PIN_INV_B] = timer_out.timer4_inverted_out_b;
      next_oe[PIN_INV_B] = 1'b1;
    end
    if (inv_a_sel)
    begin
      next_out[PIN_INV_A] = timer_out.timer4_inverted_out_a;
      next_oe[PIN_INV_A] = 1'b1;
    end
    if (io_b_sel)
    begin
      next_out[PIN_IO_B] = timer_out.timer4_io_b;
      next_oe[PIN_IO_B] = 1'b1;
    end
    if (io_a_sel)
    begin
      next_out[PIN_IO_A] = timer_out.timer4_io_a;
      next_oe[PIN_IO_A] = 1'b1;
    end
  end

  // Outputs registered; held through software standby as nothing clears them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // Feeds into timer and converter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_feed <= '{capture_a: 1'b0, capture_b: 1'b0, conv_external_trigger_n: 1'b1};
    else
    begin
      // Trigger path ignores direction on purpose
      pin_feed.conv_external_trigger_n <= conv_trigger_enable ? pin_level[PIN_TRIG] : 1'b1;
      pin_feed.capture_b <= (~timer_ctrl.combination_mode_bit & ~timer_ctrl.pwm_select_ch4
                             & timer_ctrl.b_io_ctrl[2]) ? pin_level[PIN_IO_B] : 1'b0;
      pin_feed.capture_a <= (~timer_ctrl.combination_mode_bit & ~timer_ctrl.pwm_select_ch4
                             & timer_ctrl.a_io_ctrl[2]) ? pin_level[PIN_IO_A] : 1'b0;
    end
  end

endmodule : port_b_pin_function_mux
`default_nettype wire

// [sim/port_b_mux_assertions.sv]
`default_nettype none
module port_b_mux_assertions #(
  parameter int unsigned ADDR_W = 18
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hw_standby,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire port_b_mux_pkg::timer_ctrl_t timer_ctrl,
  input wire port_b_mux_pkg::timer_out_t timer_out,
  input wire logic conv_trigger_enable,
  input wire port_b_mux_pkg::pin_feed_t pin_feed,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import port_b_mux_pkg::*;
  logic [1:0] up;

  // Quiet until the reset synchroniser has let go
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (up != 2'h3);

  property p_dir_ones;
    avs_read && !avs_waitrequest && avs_address == ADDR_W'({DIR_INDEX, 2'h0}) |-> avs_readdata[7:0] == 8'hFF;
  endproperty
  a_dir_ones: assert property (p_dir_ones) else $error("direction read not all ones");
  property p_hw_clear;
    hw_standby |=> ##1 !pin_oe[7];
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("pin 7 driven after standby clear");
  property p_no_pin6;
    !pin_oe[6] && !pin_out[6];
  endproperty
  a_no_pin6: assert property (p_no_pin6) else $error("bit 6 drives a pin");
  property p_trig_off;
    !conv_trigger_enable |=> pin_feed.conv_external_trigger_n;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger active while disabled");
  property p_inv_b;
    timer_ctrl.combination_mode_bit && timer_ctrl.inv_out_b_enable
      |=> pin_oe[5] && pin_out[5] == $past(timer_out.timer4_inverted_out_b);
  endproperty
  a_inv_b: assert property (p_inv_b) else $error("pin 5 not inverted timer b");
  property p_inv_a;
    timer_ctrl.combination_mode_bit && timer_ctrl.inv_out_a_enable
      |=> pin_oe[4] && pin_out[4] == $past(timer_out.timer4_inverted_out_a);
  endproperty
  a_inv_a: assert property (p_inv_a) else $error("pin 4 not inverted timer a");
  property p_cmp_b;
    timer_ctrl.out_b_enable && (timer_ctrl.combination_mode_bit
      || (!timer_ctrl.b_io_ctrl[2] && timer_ctrl.b_io_ctrl[1:0] != 2'h0))
      |=> pin_oe[3] && pin_out[3] == $past(timer_out.timer4_io_b);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("pin 3 not timer b output");
  property p_cap_b;
    timer_ctrl.combination_mode_bit || timer_ctrl.pwm_select_ch4 || !timer_ctrl.b_io_ctrl[2]
      |=> !pin_feed.capture_b;
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("capture b fed while deselected");

  c_read: cover property (avs_read && !avs_waitrequest);
  c_inv: cover property (timer_ctrl.combination_mode_bit && timer_ctrl.inv_out_b_enable);
  c_capture: cover property (pin_feed.capture_b);
endmodule : port_b_mux_assertions

bind port_b_pin_function_mux port_b_mux_assertions #(.ADDR_W(ADDR_W)) port_b_mux_assertions_i (
  .core_clk, .rst_b, .hw_standby, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest,
  .timer_ctrl, .timer_out, .conv_trigger_enable, .pin_feed, .pin_out, .pin_oe
);
`default_nettype wire

// [sim/board_pins.sv]
`default_nettype none
module board_pins (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board drives only where the port has let go
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : board_pins
`default_nettype wire

// [sim/test_port_b_pin_function_mux.sv]
`default_nettype none
module test_port_b_pin_function_mux;
  timeunit 1ns;
  timeprecision 1ps;
  import port_b_mux_pkg::*;
  logic core_clk, rst_b, hw_standby, avs_read, avs_write, avs_waitrequest, conv_trigger_enable;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] pin_in, pin_out, pin_oe, ext_level, q, dir_m, data_m, en_m;
  timer_ctrl_t timer_ctrl;
  timer_out_t timer_out;
  pattern_ctrl_t pattern_ctrl;
  pin_feed_t pin_feed;
  int bad_count, n_checks, seed;
  localparam logic [17:0] DIR_A = {DIR_INDEX, 2'h0};
  localparam logic [17:0] DATA_A = {DATA_INDEX, 2'h0};

  port_b_pin_function_mux port_b_pin_function_mux_i (.core_clk, .rst_b, .hw_standby, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_ctrl,
    .timer_out, .pattern_ctrl, .conv_trigger_enable, .pin_feed, .pin_in, .pin_out, .pin_oe);
  board_pins board_pins_i (.pin_out, .pin_oe, .ext_level, .pin_in);

  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    #200000;
    bad_count++;
    test_done();
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge; a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr_data(input logic [7:0] d);
    data_m = (data_m & en_m) | (d & ~en_m);
    bus(1, DATA_A, d);
  endtask : wr_data

  task automatic check_all();
    logic [7:0] e;
    e = (dir_m & data_m) | (~dir_m & ext_level);
    e[6] = dir_m[6] ? data_m[6] : 1'b1;
    bus(0, DATA_A, 8'h00);
    chk("data", e, q);
    chk("oe", dir_m & 8'hBF, pin_oe);
    chk("out", dir_m & data_m & 8'hBF, pin_out & pin_oe);
  endtask : check_all

  // Timer and trigger muxing model, pins looped back through the board model
  task automatic check_timer();
    logic [7:0] oe_e, out_e, lvl, e;
    logic sel2, sel3, sel4, sel5, cap_a, cap_b;
    sel5 = timer_ctrl.combination_mode_bit & timer_ctrl.inv_out_b_enable;
    sel4 = timer_ctrl.combination_mode_bit & timer_ctrl.inv_out_a_enable;
    sel3 = timer_ctrl.out_b_enable & (timer_ctrl.combination_mode_bit
           | (!timer_ctrl.b_io_ctrl[2] & (timer_ctrl.b_io_ctrl[1:0] != 2'h0)));
    sel2 = timer_ctrl.out_a_enable & (timer_ctrl.combination_mode_bit | timer_ctrl.pwm_select_ch4
           | (!timer_ctrl.a_io_ctrl[2] & (timer_ctrl.a_io_ctrl[1:0] != 2'h0)));
    oe_e = (dir_m & 8'hBF) | {2'h0, sel5, sel4, sel3, sel2, 2'h0};
    out_e = data_m & 8'hBF;
    out_e[5] = sel5 ? timer_out.timer4_inverted_out_b : data_m[5];
    out_e[4] = sel4 ? timer_out.timer4_inverted_out_a : data_m[4];
    out_e[3] = sel3 ? timer_out.timer4_io_b : data_m[3];
    out_e[2] = sel2 ? timer_out.timer4_io_a : data_m[2];
    lvl = (oe_e & out_e) | (~oe_e & ext_level);
    e = (dir_m & data_m) | (~dir_m & lvl);
    e[6] = dir_m[6] ? data_m[6] : 1'b1;
    cap_b = !timer_ctrl.combination_mode_bit && !timer_ctrl.pwm_select_ch4 && timer_ctrl.b_io_ctrl[2] && lvl[3];
    cap_a = !timer_ctrl.combination_mode_bit && !timer_ctrl.pwm_select_ch4 && timer_ctrl.a_io_ctrl[2] && lvl[2];
    chk("feed", {5'h00, cap_a, cap_b, !conv_trigger_enable || lvl[7]}, {5'h00, pin_feed});
    chk("t_oe", oe_e, pin_oe);
    chk("t_out", out_e & oe_e, pin_out & oe_e);
    bus(0, DATA_A, 8'h00);
    chk("t_data", e, q);
  endtask : check_timer

  initial
  begin
    rst_b = 0;
    hw_standby = 0;
    avs_address = '0;
    avs_read = 0;
    avs_write = 0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    timer_ctrl = '0;
    timer_out = '0;
    pattern_ctrl = '0;
    conv_trigger_enable = 0;
    ext_level = 8'h5A;
    dir_m = 0;
    data_m = 0;
    en_m = 0;
    bad_count = 0;
    n_checks = 0;
    seed = $urandom(88);
    repeat (10) @(posedge core_clk);
    rst_b <= 1;
    repeat (8) @(posedge core_clk);
    check_all();
    bus(0, DIR_A, 8'h00);
    chk("dir", 8'hFF, q);
    bus(1, 18'h00010, 8'h55);
    bus(0, 18'h00010, 8'h00);
    chk("unmapped", 8'h00, q);
    repeat (100)
    begin
      dir_m = 8'($urandom);
      bus(1, DIR_A, dir_m);
      wr_data(8'($urandom));
      ext_level <= 8'($urandom);
      repeat (8) @(posedge core_clk);
      check_all();
    end
    // ----------------------------------------
    // Pattern transfer
    // ----------------------------------------
    en_m = 8'h81;
    pattern_ctrl.next_data_enable_b <= 8'h81;
    dir_m = 8'hFF;
    bus(1, DIR_A, 8'hFF);
    wr_data(~data_m);
    check_all();
    pattern_ctrl.next_data_hold_b <= ~data_m;
    pattern_ctrl.transfer <= 1;
    @(posedge core_clk);
    pattern_ctrl.transfer <= 0;
    data_m = data_m ^ en_m;
    @(posedge core_clk);
    check_all();
    pattern_ctrl.next_data_enable_b <= 8'h00;
    en_m = 0;
    hw_standby <= 1;
    @(posedge core_clk);
    hw_standby <= 0;
    dir_m = 0;
    data_m = 0;
    repeat (8) @(posedge core_clk);
    check_all();
    dir_m = 8'hFF;
    bus(1, DIR_A, 8'hFF);
    check_all();
    // Write without the low byte lane must leave the data register alone
    avs_byteenable <= 4'h2;
    bus(1, DATA_A, 8'hFF);
    avs_byteenable <= 4'h1;
    check_all();
    // ----------------------------------------
    // Timer and trigger muxing
    // ----------------------------------------
    repeat (300)
    begin
      dir_m = 8'($urandom);
      bus(1, DIR_A, dir_m);
      wr_data(8'($urandom));
      timer_ctrl <= 12'($urandom);
      timer_out <= 4'($urandom);
      conv_trigger_enable <= 1'($urandom);
      ext_level <= 8'($urandom);
      repeat (7) @(posedge core_clk);
      check_timer();
    end
    test_done();
  end
endmodule : test_port_b_pin_function_mux
`default_nettype wire
